// file: uart_frame_check_addr_filter_tb.sv
// testbench for ufa_top: framing check, address filter, irq
// assumes ufa_line_model as far end, ce held high
`timescale 1ns/10ps
module uart_frame_check_addr_filter_tb;
  reg pclk, presetn, psel, penable, pwrite, rerr;
  reg [7:0] paddr, tb_byte;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, rxd_in, txd_out, irq;
  integer error_cnt, samples_checked, i;
  reg [7:0] tab [0:4];
  ufa_top DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_in),
    .txd_out(txd_out), .irq(irq));
  ufa_line_model line (.pclk(pclk), .txd_out(txd_out), .rxd_in(rxd_in));
  // ==========
  // apb master: hold request until pready is sampled
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (pready !== 1'b1) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: no pready", $time);
        stop_test;
      end
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  function hit(input [7:0] a, input [7:0] s, input [7:0] m);
    hit = (((a ^ s) & m) == 8'h00) || ((a & (s | m)) == (s | m));
  endfunction
  // ==========
  // scenarios
  task t_reset;
    begin
      apb(0, 8'h10, 0);
      cmp(rd, 0);
      apb(0, 8'h14, 0);
      cmp(rd, 0);
      apb(0, 8'h20, 0);
      cmp(rerr, 1);
    end
  endtask
  // bad stop; done flag probed between last data and stop sample
  task t_frame(input fce);
    begin
      apb(1, 8'h04, fce);
      apb(1, 8'h00, 32'h5);
      fork
        line.send(8'ha5, 0, 0, 0);
        begin
          wait (rxd_in === 1'b0);
          repeat (143) @(posedge pclk);
          apb(0, 8'h00, 0);
          cmp(rd[8], !fce);
        end
      join
      apb(0, 8'h00, 0);
      cmp(rd[9:8], {fce, 1'b1});
      apb(0, 8'h0c, 0);
      cmp(rd[7:0], 8'ha5);
      apb(1, 8'h00, 32'h105);
    end
  endtask
  task t_sticky;
    begin
      line.send(8'h3c, 0, 0, 1);
      apb(0, 8'h00, 0);
      cmp(rd[9:8], 2'h3);
      apb(1, 8'h00, 32'h305);
      apb(0, 8'h00, 0);
      cmp(rd & 32'h700, 0);
    end
  endtask
  task t_filter;
    begin
      apb(1, 8'h04, 0);
      apb(1, 8'h00, 32'he);
      line.send(8'h3c, 1, 1, 1);
      apb(0, 8'h00, 0);
      cmp(rd[8], 1);
      apb(1, 8'h00, 32'h10e);
      apb(1, 8'h10, 8'hf1);
      apb(1, 8'h14, 8'hfa);
      for (i = 0; i < 5; i = i + 1) begin
        line.send(tab[i], 1, 1, 1);
        apb(0, 8'h00, 0);
        cmp(rd[8], hit(tab[i], 8'hf1, 8'hfa));
        apb(1, 8'h00, 32'h10e);
      end
      line.send(8'hff, 1, 0, 1);
      apb(0, 8'h00, 0);
      cmp(rd[8], 0);
    end
  endtask
  task t_irq;
    begin
      apb(1, 8'h1c, 32'h100);
      line.send(8'hff, 1, 1, 1);
      repeat (2) @(posedge pclk);
      cmp(irq, 1);
      apb(1, 8'h1c, 0);
      repeat (2) @(posedge pclk);
      cmp(irq, 0);
      apb(1, 8'h1c, 32'h100);
      repeat (2) @(posedge pclk);
      cmp(irq, 1);
      apb(1, 8'h00, 32'h10e);
      repeat (2) @(posedge pclk);
      cmp(irq, 0);
    end
  endtask
  // send and receive side by side, tx twice as slow as rx
  task t_duplex;
    begin
      apb(1, 8'h18, 32'h1);
      apb(1, 8'h00, 32'h5);
      fork
        line.get(32, tb_byte);
        begin
          apb(1, 8'h08, 8'h3c);
          apb(0, 8'h00, 0);
          cmp(rd[6], 1);
          line.send(8'h96, 0, 0, 1);
        end
      join
      cmp(tb_byte, 8'h3c);
      apb(0, 8'h0c, 0);
      cmp(rd[7:0], 8'h96);
      // tx frame is 320 clocks long, so it ends well before this read
      repeat (60) @(posedge pclk);
      apb(0, 8'h00, 0);
      cmp(rd[10:8], 3'h5);
      cmp(rd[6], 0);
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ==========
  // clock, watchdog, main sequence
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #400000;
    error_cnt = error_cnt + 1;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test;
  end
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    tab[0] = 8'hf0;
    tab[1] = 8'hf3;
    tab[2] = 8'hff;
    tab[3] = 8'hfb;
    tab[4] = 8'h71;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_frame(0);
    t_frame(1);
    t_sticky;
    t_filter;
    t_irq;
    t_duplex;
    stop_test;
  end
endmodule // uart_frame_check_addr_filter_tb

// file: ufa_chk_sva.sv
// checker: apb answer and serial line of ufa_top
// bound to ufa_top, sees its ports only, ce assumed high
`timescale 1ns/10ps
module ufa_chk (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire txd_out
);
  // ==========
  // register bus and line checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_wait_one: assert property (psel && penable && !pready && ce |=> pready) else $error("late ready");
  chk_ready_pulse: assert property (pready && ce |=> !pready) else $error("long ready");
  chk_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
  chk_err_pair: assert property (pslverr |-> pready) else $error("stray error");
  chk_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("err data");
  chk_map_ok: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped error");
  chk_map_err: assert property (pready && paddr > 8'h1c |-> pslverr) else $error("no error");
  chk_rdata_hold: assert property (!pready |-> $stable(prdata)) else $error("data moved");
  // a start bit lasts at least 16 clocks, so 8 is safe
  chk_start_len: assert property ($fell(txd_out) |-> (!txd_out) [*8]) else $error("short start");
endmodule // ufa_chk
bind ufa_top ufa_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_out(txd_out));

// file: ufa_defines.vh
// constants for the serial port with framing check and address filter
// assumes a 32-bit apb master on pclk; included by ufa_top.v only
// ==========================================================
// Summary of operation
// RULE1: three asynchronous modes, enhancements in each; mode 1 here has no address filter, mpe acts in modes 2 and 3 only
// RULE2: transmitter and receiver run independently, own baud
// RULE3: framing check only while enable bit set
// RULE4: invalid stop bit sets framing error flag
// RULE5: framing error flag sticky until software or reset
// RULE6: checking on, receive done at stop bit
// RULE7: given address match under mask bits
// RULE8: broadcast is address or mask, zeros ignored
// RULE9: reset clears address and mask, accept all
// RULE10: master sends all ones to reach everyone
// RULE11: address frames filtered in nine-bit modes
`ifndef UFA_DEFINES_VH
`define UFA_DEFINES_VH
// ==========================================================
// register byte offsets
`define UFA_OFS_CTRL 8'h00
`define UFA_OFS_PWR 8'h04
`define UFA_OFS_TXD 8'h08
`define UFA_OFS_RXD 8'h0c
`define UFA_OFS_ADDR 8'h10
`define UFA_OFS_SMASK 8'h14
`define UFA_OFS_BAUD 8'h18
`define UFA_OFS_IMASK 8'h1c
// ==========================================================
// serial_control_reg fields
`define UFA_B_MODE 1:0
`define UFA_B_REN 2
`define UFA_B_MPE 3
`define UFA_B_TB8 4
`define UFA_B_RB8 5
`define UFA_B_TXBSY 6
`define UFA_B_RDONE 8
`define UFA_B_FERR 9
`define UFA_B_TDONE 10
`define UFA_B_FLAGS 10:8
// power_control_reg field
`define UFA_B_FCE 0
// ==========================================================
// reset values and timing
`define UFA_RST_ADDR 8'h00
`define UFA_RST_BAUD 16'h0000
`define UFA_MODE_8BIT 2'h1
`define UFA_MODE_OFF 2'h0
`define UFA_SUB_MID 4'h7
`define UFA_SUB_LAST 4'hf
`define UFA_BITS_M1 4'h9
`define UFA_BITS_M23 4'ha
`define UFA_DBITS_M1 4'h8
`define UFA_DBITS_M23 4'h9
`endif

// file: ufa_line_model.sv
// far-end processor on the serial line
// assumes pclk at 100 MHz, line idle high
`timescale 1ns/10ps
module ufa_line_model (
  input wire pclk,
  input wire txd_out,
  output reg rxd_in
);
  // ==========
  // sender, 16 clocks a bit, lsb first
  initial rxd_in = 1'b1;
  task automatic send(input [7:0] d, input nine, input b9, input stp);
    integer i;
    reg [10:0] f;
    begin
      f = nine ? {1'b1, stp, b9, d, 1'b0} : {1'b1, 1'b1, stp, d, 1'b0};
      for (i = 0; i < 11; i = i + 1) begin
        @(posedge pclk) rxd_in <= f[i];
        repeat (15) @(posedge pclk);
      end
    end
  endtask
  // receiver, samples mid bit of a frame sent by the block
  task automatic get(input integer per, output [7:0] d);
    integer i;
    begin
      @(negedge txd_out);
      repeat (per / 2) @(posedge pclk);
      for (i = 0; i < 8; i = i + 1) begin
        repeat (per) @(posedge pclk);
        d[i] = txd_out;
      end
    end
  endtask
endmodule // ufa_line_model

// file: ufa_top.v
// uart core with stop-bit framing check and slave address filter
// assumes apb master on pclk, rxd_in asynchronous to pclk
`timescale 1ns/10ps
`include "ufa_defines.vh"
module ufa_top (
  input wire pclk,
  input wire presetn,
  input wire ce, // freezes all state while low
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd_in, // serial line in
  output reg txd_out, // serial line out
  output reg irq // level interrupt
);
  // ==========================================================
  // registers
  reg [1:0] mode_r; // 0 off, 1..3 async modes
  reg ren_r; // receiver enable
  reg mpe_r; // multiprocessor address filtering
  reg tb8_r; // ninth bit to send
  reg rb8_r; // ninth bit received
  reg [2:0] flag_r; // tx done, framing error, rx done
  reg [2:0] imask_r; // interrupt mask, same layout
  reg fce_r; // framing_check_enable
  reg [7:0] slave_addr_reg_r; // slave_addr_reg
  reg [7:0] smask_r; // slave_addr_mask_reg
  reg [15:0] tdiv_r; // tx tick divisor
  reg [15:0] rdiv_r; // rx tick divisor
  reg [7:0] rxbuf_r; // last accepted byte
  // line sync
  reg rx_m_r; // first stage, read only by rx_s_r
  reg rx_s_r; // second stage
  // transmitter
  reg tx_busy_r;
  reg [10:0] tsh_r; // shift register, lsb first
  reg [3:0] tbits_r; // bits left
  reg [3:0] tsub_r; // sixteenths of a bit
  reg [15:0] tcnt_r; // baud divider
  // receiver
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rst_r; // receiver state
  reg [3:0] rsub_r;
  reg [15:0] rcnt_r;
  reg [3:0] rbit_r; // data bits taken
  reg [8:0] rsh_r; // data collected
  reg rdone_late_r; // done still owed at stop bit

  // ==========================================================
  // apb decode
  wire acc = psel & penable & ~pready; // one access cycle
  wire wr = psel & penable & pready & pwrite; // lands at the edge that completes the transfer
  wire hit = (paddr == `UFA_OFS_CTRL) || (paddr == `UFA_OFS_PWR) || (paddr == `UFA_OFS_TXD) ||
             (paddr == `UFA_OFS_RXD) || (paddr == `UFA_OFS_ADDR) || (paddr == `UFA_OFS_SMASK) ||
             (paddr == `UFA_OFS_BAUD) || (paddr == `UFA_OFS_IMASK);
  wire nine = (mode_r != `UFA_MODE_8BIT); // modes 2 and 3 carry a ninth bit
  wire [3:0] nbits = nine ? `UFA_DBITS_M23 : `UFA_DBITS_M1; // data bits per frame
  wire ttick = (tcnt_r == tdiv_r); // separate dividers per direction
  wire rtick = (rcnt_r == rdiv_r);
  // address compare on the eight low received bits
  wire [7:0] bcast = slave_addr_reg_r | smask_r; // broadcast pattern
  wire given_hit = (((rsh_r[7:0] ^ slave_addr_reg_r) & smask_r) == 8'h00); // RULE7 RULE9
  wire bcast_hit = (((rsh_r[7:0] ^ bcast) & bcast) == 8'h00); // RULE8 RULE10
  // nine-bit frames with filtering on: only matching address frames pass
  wire accept = ~(mpe_r & nine) | (rsh_r[8] & (given_hit | bcast_hit)); // RULE11
  // events
  reg ev_rdone;
  reg ev_ferr;
  reg ev_tdone;

  // ==========================================================
  // read mux
  reg [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    if (paddr == `UFA_OFS_CTRL) begin
      rdata[`UFA_B_MODE] = mode_r;
      rdata[`UFA_B_REN] = ren_r;
      rdata[`UFA_B_MPE] = mpe_r;
      rdata[`UFA_B_TB8] = tb8_r;
      rdata[`UFA_B_RB8] = rb8_r;
      rdata[`UFA_B_TXBSY] = tx_busy_r;
      rdata[`UFA_B_FLAGS] = flag_r;
    end else if (paddr == `UFA_OFS_PWR) begin
      rdata[`UFA_B_FCE] = fce_r;
    end else if (paddr == `UFA_OFS_RXD) begin
      rdata[7:0] = rxbuf_r;
    end else if (paddr == `UFA_OFS_ADDR) begin
      rdata[7:0] = slave_addr_reg_r;
    end else if (paddr == `UFA_OFS_SMASK) begin
      rdata[7:0] = smask_r;
    end else if (paddr == `UFA_OFS_BAUD) begin
      rdata = {rdiv_r, tdiv_r};
    end else if (paddr == `UFA_OFS_IMASK) begin
      rdata[`UFA_B_FLAGS] = imask_r;
    end
  end

  // ==========================================================
  // apb answer, one wait cycle, registered outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else if (ce) begin
      pready <= acc;
      pslverr <= acc & ~hit; // unmapped address answers with error
      if (acc && !pwrite) begin
        prdata <= rdata;
      end
      irq <= |(flag_r & imask_r);
    end
  end

  // ==========================================================
  // control registers and sticky flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `UFA_MODE_OFF;
      ren_r <= 1'b0;
      mpe_r <= 1'b0;
      tb8_r <= 1'b0;
      flag_r <= 3'h0;
      imask_r <= 3'h0;
      fce_r <= 1'b0;
      slave_addr_reg_r <= `UFA_RST_ADDR; // RULE9
      smask_r <= `UFA_RST_ADDR; // RULE9
      tdiv_r <= `UFA_RST_BAUD;
      rdiv_r <= `UFA_RST_BAUD;
    end else if (ce) begin
      if (wr && paddr == `UFA_OFS_CTRL) begin
        mode_r <= pwdata[`UFA_B_MODE]; // RULE1
        ren_r <= pwdata[`UFA_B_REN];
        mpe_r <= pwdata[`UFA_B_MPE];
        tb8_r <= pwdata[`UFA_B_TB8];
      end
      if (wr && paddr == `UFA_OFS_PWR) begin
        fce_r <= pwdata[`UFA_B_FCE];
      end
      if (wr && paddr == `UFA_OFS_ADDR) begin
        slave_addr_reg_r <= pwdata[7:0];
      end
      if (wr && paddr == `UFA_OFS_SMASK) begin
        smask_r <= pwdata[7:0];
      end
      if (wr && paddr == `UFA_OFS_BAUD) begin
        tdiv_r <= pwdata[15:0];
        rdiv_r <= pwdata[31:16];
      end
      if (wr && paddr == `UFA_OFS_IMASK) begin
        imask_r <= pwdata[`UFA_B_FLAGS];
      end
      // write one clears, a same-cycle event wins; valid frames never clear
      flag_r <= (flag_r & ~((wr && paddr == `UFA_OFS_CTRL) ? pwdata[`UFA_B_FLAGS] : 3'h0)) |
                {ev_tdone, ev_ferr, ev_rdone}; // RULE5
    end
  end

  // ==========================================================
  // line input synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
    end else if (ce) begin
      rx_m_r <= rxd_in;
      rx_s_r <= rx_m_r;
    end
  end

  // ==========================================================
  // transmitter, independent of the receiver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy_r <= 1'b0;
      tsh_r <= 11'h7ff;
      tbits_r <= 4'h0;
      tsub_r <= 4'h0;
      tcnt_r <= 16'h0000;
      txd_out <= 1'b1;
      ev_tdone <= 1'b0;
    end else if (ce) begin
      ev_tdone <= 1'b0;
      tcnt_r <= ttick ? 16'h0000 : tcnt_r + 16'h0001; // RULE2
      if (!tx_busy_r) begin
        txd_out <= 1'b1;
        // a write while busy or with the port off is dropped
        if (wr && paddr == `UFA_OFS_TXD && mode_r != `UFA_MODE_OFF) begin
          tx_busy_r <= 1'b1;
          tsh_r <= nine ? {1'b1, tb8_r, pwdata[7:0], 1'b0} : {2'h3, pwdata[7:0], 1'b0};
          tbits_r <= nine ? `UFA_BITS_M23 + 4'h1 : `UFA_BITS_M1 + 4'h1;
          tsub_r <= 4'h0;
          tcnt_r <= 16'h0000;
        end
      end else if (ttick) begin
        if (tsub_r == 4'h0) begin
          // start of a bit time: present next bit
          txd_out <= tsh_r[0];
          tsh_r <= {1'b1, tsh_r[10:1]};
        end
        tsub_r <= tsub_r + 4'h1;
        if (tsub_r == `UFA_SUB_LAST) begin
          tbits_r <= tbits_r - 4'h1;
          if (tbits_r == 4'h1) begin
            tx_busy_r <= 1'b0;
            ev_tdone <= 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // receiver: sixteen ticks per bit, sample at the middle
  // start is re-checked at mid bit so short glitches are dropped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_r <= RX_IDLE;
      rsub_r <= 4'h0;
      rcnt_r <= 16'h0000;
      rbit_r <= 4'h0;
      rsh_r <= 9'h000;
      rxbuf_r <= 8'h00;
      rb8_r <= 1'b0;
      rdone_late_r <= 1'b0;
      ev_rdone <= 1'b0;
      ev_ferr <= 1'b0;
    end else if (ce) begin
      ev_rdone <= 1'b0;
      ev_ferr <= 1'b0;
      rcnt_r <= rtick ? 16'h0000 : rcnt_r + 16'h0001; // RULE2
      if (rtick) begin
        rsub_r <= rsub_r + 4'h1;
      end
      case (rst_r)
        RX_IDLE: begin
          if (ren_r && mode_r != `UFA_MODE_OFF && !rx_s_r) begin
            rst_r <= RX_START;
            rsub_r <= 4'h0;
            rcnt_r <= 16'h0000;
          end
        end
        RX_START: begin
          if (rtick && rsub_r == `UFA_SUB_MID) begin
            if (rx_s_r) begin
              rst_r <= RX_IDLE; // false start
            end else begin
              rst_r <= RX_DATA;
              rbit_r <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (rtick && rsub_r == `UFA_SUB_MID) begin
            // lsb first; eight-bit frames end with a zero ninth bit
            rsh_r <= nine ? {rx_s_r, rsh_r[8:1]} : {1'b0, rx_s_r, rsh_r[7:1]};
            rbit_r <= rbit_r + 4'h1;
            if (rbit_r + 4'h1 == nbits) begin
              rst_r <= RX_STOP;
              rdone_late_r <= fce_r; // RULE6
            end
          end
        end
        RX_STOP: begin
          // without the check the frame is delivered at the last data bit
          if (!rdone_late_r && rbit_r == nbits) begin
            rbit_r <= 4'h0;
            if (accept) begin // RULE11
              rxbuf_r <= rsh_r[7:0];
              rb8_r <= rsh_r[8];
              ev_rdone <= 1'b1; // RULE6
            end
          end
          if (rtick && rsub_r == `UFA_SUB_MID) begin
            rst_r <= RX_IDLE;
            rdone_late_r <= 1'b0;
            // check only while enabled; a bad stop bit flags the error
            if (rdone_late_r && !rx_s_r) begin
              ev_ferr <= 1'b1; // RULE3 RULE4
            end
            if (rdone_late_r && accept) begin
              rxbuf_r <= rsh_r[7:0];
              rb8_r <= rsh_r[8];
              ev_rdone <= 1'b1; // RULE6
            end
          end
        end
        default: begin
          rst_r <= RX_IDLE;
        end
      endcase
    end
  end
endmodule // ufa_top
